// *** rtl/vcps_params.svh ***
// Constants of the virtual-channel packet and broadcast service port
`ifndef VCPS_PARAMS_SVH
`define VCPS_PARAMS_SVH

`define VCPS_NUM_VC 4
`define VCPS_VC_W 2
`define VCPS_CHAR_W 8
`define VCPS_FIFO_DEPTH 32
`define VCPS_PEND_W 6
`define VCPS_LOGICAL_ADDR_MIN 8'h20
`define VCPS_BC_MSG_BYTES 8
`define VCPS_BC_CHAN_W 8
`define VCPS_BC_SEQ_W 8
`define VCPS_BC_TYPE_W 8
`define VCPS_BC_CLASS_W 4

`endif

// *** rtl/vcps_pkg.sv ***
// Types of the virtual-channel packet and broadcast service port
`include "vcps_params.svh"

package vcps_pkg;

  // One character of a packet: data byte or end_of_packet_marker
  typedef struct packed {
    logic eop;
    logic [`VCPS_CHAR_W-1:0] data;
  } vcps_char_t;

  // Character tagged with its virtual_channel, as it crosses the link
  typedef struct packed {
    logic [`VCPS_VC_W-1:0] vc;
    vcps_char_t ch;
  } vcps_link_char_t;

  typedef struct packed {
    logic [`VCPS_BC_CHAN_W-1:0] channel;
    logic [`VCPS_BC_SEQ_W-1:0] seq;
    logic [`VCPS_BC_TYPE_W-1:0] btype;
    logic late;
    logic [`VCPS_BC_MSG_BYTES*8-1:0] msg;
  } vcps_bcast_t;

  typedef struct packed {
    logic [`VCPS_VC_W-1:0] vc;
    logic logical;
    logic [`VCPS_CHAR_W-1:0] first_addr;
  } vcps_arrival_t;

  typedef struct packed {
    logic tx_lock;
    logic [`VCPS_VC_W-1:0] tx_vc;
    logic link_tx_valid;
    vcps_link_char_t link_tx;
    logic [`VCPS_NUM_VC-1:0] rx_first;
    logic [`VCPS_NUM_VC-1:0][`VCPS_PEND_W-1:0] pend_cnt;
    logic [`VCPS_NUM_VC-1:0] pending;
    logic arr_valid;
    vcps_arrival_t arr;
    logic bc_tx_valid;
    vcps_bcast_t bc_tx;
    logic bc_notify;
    vcps_bcast_t bc_rx;
  } vcps_port_state_t;

endpackage : vcps_pkg

// *** rtl/vcps_fifo.sv ***
// Character FIFO with registered output stage, valid and ready on both sides
`timescale 1ns/100ps

module vcps_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
    logic [W-1:0] out_data;
  } vcps_fifo_state_t;

  vcps_fifo_state_t s_r;
  vcps_fifo_state_t s_nxt;
  logic push;
  logic pop_out;
  logic load;

  always_comb
  begin
    s_nxt = s_r;
    push = in_valid_i && s_r.in_ready;
    pop_out = s_r.out_valid && out_ready_i;
    // Output stage refills from storage so data leaves from a flop
    load = (!s_r.out_valid || pop_out) && (s_r.count != '0);
    if (pop_out)
    begin
      s_nxt.out_valid = 1'b0;
    end
    if (load)
    begin
      s_nxt.out_data = s_r.mem[s_r.rptr];
      s_nxt.out_valid = 1'b1;
      s_nxt.rptr = s_r.rptr + 1'b1;
    end
    if (push)
    begin
      s_nxt.mem[s_r.wptr] = in_data_i;
      s_nxt.wptr = s_r.wptr + 1'b1;
    end
    s_nxt.count = s_r.count + CW'(push) - CW'(load);
    s_nxt.in_ready = (s_nxt.count != CW'(DEPTH));
    if (sys_rst_i)
    begin
      s_nxt = '0;
      s_nxt.in_ready = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    s_r <= s_nxt;
  end

  assign in_ready_o = s_r.in_ready;
  assign out_valid_o = s_r.out_valid;
  assign out_data_o = s_r.out_data;

endmodule : vcps_fifo

// *** rtl/vcps_port.sv ***
// Virtual-channel packet and broadcast service port of a serial link codec
`timescale 1ns/100ps
`include "vcps_params.svh"

// Contract
// (R1) Same number of receive buffers as transmit buffers, one pair per channel.
// (R2) Each transmit buffer takes data characters and end markers through a FIFO write.
// (R3) User writes address, then cargo, then end marker into one transmit buffer.
// (R4) Each receive buffer gives received characters and end markers through a FIFO read.
// (R5) Fixed eight-byte broadcasts reach every node, carrying time, sync or events.
// (R6) Outgoing broadcast holding set and a matching received broadcast set.
// (R7) User subscribes to broadcast classes; only subscribed arrivals are notified.
// (R8) User issues a send naming one channel and carrying the packet.
// (R9) Each accepted packet goes out on exactly the channel it was written to.
// (R10) Arrival notice names channel and packet, and shows it waits to be read.
// (R11) User reads the arrived packet from the channel named in the notice.
// (R12) Leading address byte is classed as path or logical addressing.
// (R13) Full buffers stall writes, empty buffers forbid reads.
module vcps_port (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // User transmit side
  input wire logic [`VCPS_NUM_VC-1:0] tx_wr_i,
  input wire vcps_pkg::vcps_char_t tx_char_i,
  output logic [`VCPS_NUM_VC-1:0] tx_ready_o,
  // User receive side
  input wire logic [`VCPS_NUM_VC-1:0] rx_rd_i,
  output vcps_pkg::vcps_char_t [`VCPS_NUM_VC-1:0] rx_char_o,
  output logic [`VCPS_NUM_VC-1:0] rx_valid_o,
  output logic [`VCPS_NUM_VC-1:0] rx_pkt_pending_o,
  output logic rx_arrival_valid_o,
  output vcps_pkg::vcps_arrival_t rx_arrival_o,
  // Link side packet stream
  output logic link_tx_valid_o,
  output vcps_pkg::vcps_link_char_t link_tx_o,
  input wire logic link_tx_ready_i,
  input wire logic link_rx_valid_i,
  input wire vcps_pkg::vcps_link_char_t link_rx_i,
  output logic [`VCPS_NUM_VC-1:0] link_rx_ready_o,
  // Broadcast service
  input wire logic bc_tx_wr_i,
  input wire vcps_pkg::vcps_bcast_t bc_tx_i,
  output logic bc_tx_busy_o,
  output logic link_bc_tx_valid_o,
  output vcps_pkg::vcps_bcast_t link_bc_tx_o,
  input wire logic link_bc_tx_ready_i,
  input wire logic link_bc_rx_valid_i,
  input wire vcps_pkg::vcps_bcast_t link_bc_rx_i,
  input wire logic [(1<<`VCPS_BC_CLASS_W)-1:0] bc_sub_mask_i,
  output logic bc_rx_notify_o,
  output vcps_pkg::vcps_bcast_t bc_rx_o
);

  localparam int NV = `VCPS_NUM_VC;
  localparam int VCW = `VCPS_VC_W;
  localparam int PW = `VCPS_PEND_W;
  localparam int CHW = $bits(vcps_pkg::vcps_char_t);

  vcps_pkg::vcps_port_state_t s_r;
  vcps_pkg::vcps_port_state_t s_nxt;

  vcps_pkg::vcps_char_t [NV-1:0] tx_out_data;
  logic [NV-1:0] tx_out_valid;
  logic [NV-1:0] tx_pop;
  logic [NV-1:0] rx_in_valid;

  // ----------------------------------------------------------------
  // Per-channel buffers
  // ----------------------------------------------------------------
  // One transmit and one receive buffer per channel, always paired
  generate
    for (genvar v = 0; v < NV; v++)
    begin : g_vc
      // see (R1)
      assign rx_in_valid[v] = link_rx_valid_i && (link_rx_i.vc == VCW'(v));

      // Write port stalls when full, user waits on tx_ready_o; see (R2) see (R13)
      vcps_fifo #(
        .W(CHW),
        .DEPTH(`VCPS_FIFO_DEPTH)
      ) u_tx_fifo (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(tx_wr_i[v]),
        .in_data_i(tx_char_i),
        .in_ready_o(tx_ready_o[v]),
        .out_valid_o(tx_out_valid[v]),
        .out_data_o(tx_out_data[v]),
        .out_ready_i(tx_pop[v])
      );

      // Read port ignores reads while empty; see (R4) see (R13)
      vcps_fifo #(
        .W(CHW),
        .DEPTH(`VCPS_FIFO_DEPTH)
      ) u_rx_fifo (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(rx_in_valid[v]),
        .in_data_i(link_rx_i.ch),
        .in_ready_o(link_rx_ready_o[v]),
        .out_valid_o(rx_valid_o[v]),
        .out_data_o(rx_char_o[v]),
        .out_ready_i(rx_rd_i[v])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic found;
    logic [VCW-1:0] sel;
    logic [VCW-1:0] cand;
    logic push;
    logic inc;
    logic dec;
    found = 1'b0;
    sel = '0;
    cand = '0;
    push = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    s_nxt = s_r;
    tx_pop = '0;
    s_nxt.arr_valid = 1'b0;
    s_nxt.bc_notify = 1'b0;

    // Transmit arbiter: a started packet keeps its channel until its
    // end marker, so a packet is never split across channels
    if (!s_r.link_tx_valid || link_tx_ready_i)
    begin
      s_nxt.link_tx_valid = 1'b0;
      sel = s_r.tx_vc;
      if (s_r.tx_lock)
      begin
        found = tx_out_valid[s_r.tx_vc];
      end
      else
      begin
        // Round robin from the channel after the last one served
        for (int i = 1; i <= NV; i++)
        begin
          cand = s_r.tx_vc + VCW'(i);
          if (!found && tx_out_valid[cand])
          begin
            found = 1'b1;
            sel = cand;
          end
        end
      end
      if (found)
      begin
        tx_pop[sel] = 1'b1;
        s_nxt.link_tx_valid = 1'b1;
        s_nxt.link_tx.vc = sel; // see (R9)
        s_nxt.link_tx.ch = tx_out_data[sel];
        s_nxt.tx_lock = !tx_out_data[sel].eop; // see (R3)
        s_nxt.tx_vc = sel;
      end
    end

    // Receive bookkeeping per channel
    for (int v = 0; v < NV; v++)
    begin
      push = rx_in_valid[v] && link_rx_ready_o[v];
      if (push)
      begin
        if (s_r.rx_first[v] && !link_rx_i.ch.eop)
        begin
          // First character is the destination address; see (R10)
          s_nxt.arr_valid = 1'b1;
          s_nxt.arr.vc = VCW'(v);
          s_nxt.arr.first_addr = link_rx_i.ch.data;
          // Below the threshold it is a path address; see (R12)
          s_nxt.arr.logical = (link_rx_i.ch.data >= `VCPS_LOGICAL_ADDR_MIN);
        end
        s_nxt.rx_first[v] = link_rx_i.ch.eop;
      end
      // Whole packets waiting; a same-cycle arrival and read cancel out
      inc = push && link_rx_i.ch.eop;
      dec = rx_rd_i[v] && rx_valid_o[v] && rx_char_o[v].eop; // see (R11)
      s_nxt.pend_cnt[v] = s_r.pend_cnt[v] + PW'(inc) - PW'(dec);
      s_nxt.pending[v] = (s_nxt.pend_cnt[v] != '0); // see (R10)
    end

    // Outgoing broadcast holding set; writes while busy are dropped
    if (s_r.bc_tx_valid && link_bc_tx_ready_i)
    begin
      s_nxt.bc_tx_valid = 1'b0;
    end
    if (bc_tx_wr_i && !s_r.bc_tx_valid)
    begin
      s_nxt.bc_tx_valid = 1'b1; // see (R5)
      s_nxt.bc_tx = bc_tx_i; // see (R6)
    end

    // Received broadcasts of unsubscribed classes are not kept
    if (link_bc_rx_valid_i && bc_sub_mask_i[link_bc_rx_i.btype[`VCPS_BC_CLASS_W-1:0]])
    begin
      s_nxt.bc_rx = link_bc_rx_i; // see (R6)
      s_nxt.bc_notify = 1'b1; // see (R7)
    end

    if (sys_rst_i)
    begin
      s_nxt = '0;
      s_nxt.rx_first = '1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link_tx_valid_o = s_r.link_tx_valid;
  assign link_tx_o = s_r.link_tx; // see (R8)
  assign rx_pkt_pending_o = s_r.pending;
  assign rx_arrival_valid_o = s_r.arr_valid;
  assign rx_arrival_o = s_r.arr;
  assign bc_tx_busy_o = s_r.bc_tx_valid;
  assign link_bc_tx_valid_o = s_r.bc_tx_valid;
  assign link_bc_tx_o = s_r.bc_tx;
  assign bc_rx_notify_o = s_r.bc_notify;
  assign bc_rx_o = s_r.bc_rx;

endmodule : vcps_port

// *** tb/vcps_port_props.sv ***
// Concurrent checks on the service port's link and broadcast pins
`timescale 1ns/100ps
`include "vcps_params.svh"
module vcps_port_props (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic link_tx_valid_o,
  input wire vcps_pkg::vcps_link_char_t link_tx_o,
  input wire logic link_tx_ready_i,
  input wire logic link_rx_valid_i,
  input wire vcps_pkg::vcps_link_char_t link_rx_i,
  input wire logic rx_arrival_valid_o,
  input wire vcps_pkg::vcps_arrival_t rx_arrival_o,
  input wire logic bc_tx_wr_i,
  input wire vcps_pkg::vcps_bcast_t bc_tx_i,
  input wire logic bc_tx_busy_o,
  input wire logic link_bc_tx_valid_o,
  input wire vcps_pkg::vcps_bcast_t link_bc_tx_o,
  input wire logic link_bc_tx_ready_i,
  input wire logic link_bc_rx_valid_i,
  input wire vcps_pkg::vcps_bcast_t link_bc_rx_i,
  input wire logic [(1<<`VCPS_BC_CLASS_W)-1:0] bc_sub_mask_i,
  input wire logic bc_rx_notify_o,
  input wire vcps_pkg::vcps_bcast_t bc_rx_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic sub;
  assign sub = link_bc_rx_valid_i && bc_sub_mask_i[link_bc_rx_i.btype[3:0]];
  a_link_held: assert property (link_tx_valid_o && !link_tx_ready_i
    |=> link_tx_valid_o && $stable(link_tx_o)) else $error("link char not held");
  a_link_lock: assert property (link_tx_valid_o && link_tx_ready_i && !link_tx_o.ch.eop
    |=> !link_tx_valid_o || link_tx_o.vc == $past(link_tx_o.vc)) else $error("channel switch");
  a_arr_cause: assert property (rx_arrival_valid_o |-> $past(link_rx_valid_i)
    && rx_arrival_o.vc == $past(link_rx_i.vc)
    && rx_arrival_o.first_addr == $past(link_rx_i.ch.data)) else $error("bad arrival");
  a_arr_class: assert property (rx_arrival_valid_o |-> rx_arrival_o.logical
    == (rx_arrival_o.first_addr >= 8'h20)) else $error("bad address class");
  a_bc_take: assert property (bc_tx_wr_i && !bc_tx_busy_o
    |=> link_bc_tx_valid_o && link_bc_tx_o == $past(bc_tx_i)) else $error("bcast not held");
  a_bc_clear: assert property (link_bc_tx_valid_o && link_bc_tx_ready_i
    |=> !bc_tx_busy_o && !link_bc_tx_valid_o) else $error("bcast stuck");
  a_bc_notify: assert property (sub |=> bc_rx_notify_o
    && bc_rx_o == $past(link_bc_rx_i)) else $error("missed notify");
  a_bc_quiet: assert property (!sub |=> !bc_rx_notify_o
    && $stable(bc_rx_o)) else $error("spurious notify");
endmodule : vcps_port_props
bind vcps_port vcps_port_props vcps_port_props_inst (.*);

// *** tb/vcps_link_model.sv ***
// Remote node model: echoes link characters and broadcasts back
`timescale 1ns/100ps
module vcps_link_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire vcps_pkg::vcps_link_char_t tx_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output vcps_pkg::vcps_link_char_t rx_o,
  input wire logic [3:0] rx_ready_i,
  input wire logic bc_valid_i,
  input wire vcps_pkg::vcps_bcast_t bc_i,
  output logic bc_ready_o,
  output logic bc_rx_valid_o,
  output vcps_pkg::vcps_bcast_t bc_rx_o
);
  // One echo in flight, so a full receive buffer backs up the link
  assign tx_ready_o = !stall_i && !rx_valid_o;
  assign bc_ready_o = !stall_i;
  always_ff @(posedge core_clk_i)
  begin
    bc_rx_valid_o <= !sys_rst_i && bc_valid_i && bc_ready_o;
    bc_rx_o <= (bc_valid_i && bc_ready_o) ? bc_i : ~bc_rx_o;
    if (sys_rst_i)
    begin
      rx_valid_o <= 1'h0;
      rx_o <= '0;
      bc_rx_o <= '0;
    end
    else if (tx_valid_i && tx_ready_o)
    begin
      rx_valid_o <= 1'h1;
      rx_o <= tx_i;
    end
    else if (rx_valid_o && rx_ready_i[rx_o.vc])
    begin
      rx_valid_o <= 1'h0;
      rx_o <= ~rx_o;
    end
  end
endmodule : vcps_link_model

// *** tb/vcps_port_bench.sv ***
// Self-checking bench of the virtual-channel service port
`timescale 1ns/100ps
module vcps_port_bench;
  logic [3:0] tx_wr_i, tx_ready_o, rx_rd_i, rx_valid_o, rx_pkt_pending_o, link_rx_ready_o;
  vcps_pkg::vcps_char_t tx_char_i;
  vcps_pkg::vcps_char_t [3:0] rx_char_o;
  vcps_pkg::vcps_arrival_t rx_arrival_o, arr_q;
  vcps_pkg::vcps_link_char_t link_tx_o, link_rx_i;
  vcps_pkg::vcps_bcast_t bc_tx_i, link_bc_tx_o, link_bc_rx_i, bc_rx_o, b1;
  logic core_clk_i, sys_rst_i, stall, rx_arrival_valid_o, link_tx_valid_o, link_tx_ready_i;
  logic link_rx_valid_i, bc_tx_wr_i, bc_tx_busy_o, link_bc_tx_valid_o, link_bc_tx_ready_i;
  logic link_bc_rx_valid_i, bc_rx_notify_o;
  logic [15:0] bc_sub_mask_i;
  int error_cnt, checks_done, cyc, nt_n;
  vcps_port vcps_port_inst (.*);
  vcps_link_model vcps_link_model_inst (.core_clk_i, .sys_rst_i, .stall_i(stall),
    .tx_valid_i(link_tx_valid_o), .tx_i(link_tx_o), .tx_ready_o(link_tx_ready_i),
    .rx_valid_o(link_rx_valid_i), .rx_o(link_rx_i), .rx_ready_i(link_rx_ready_o),
    .bc_valid_i(link_bc_tx_valid_o), .bc_i(link_bc_tx_o), .bc_ready_o(link_bc_tx_ready_i),
    .bc_rx_valid_o(link_bc_rx_valid_i), .bc_rx_o(link_bc_rx_i));
  initial
  begin
    core_clk_i = 0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (rx_arrival_valid_o) arr_q <= rx_arrival_o;
    if (bc_rx_notify_o) nt_n <= nt_n + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [88:0] seen, input logic [88:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge core_clk_i) #1;
  endtask : step
  // Strobe stays up on return so back-to-back calls hit every edge
  task automatic wr(input int v, input logic [8:0] c);
    while (!tx_ready_o[v])
    begin
      tx_wr_i = '0;
      step();
    end
    tx_wr_i = 4'h1 << v;
    tx_char_i = c;
    step();
  endtask : wr
  task automatic rd(input int v, output logic [8:0] c, output logic p);
    while (!rx_valid_o[v])
    begin
      rx_rd_i = '0;
      step();
    end
    c = rx_char_o[v];
    p = rx_pkt_pending_o[v];
    rx_rd_i = 4'h1 << v;
    step();
  endtask : rd
  task automatic t_pkt();
    logic [8:0] c;
    logic [7:0] a;
    logic p;
    for (int v = 0; v < 4; v++)
    begin
      a = v[0] ? 8'h20 : 8'h1f;
      wr(v, {1'h0, a});
      wr(v, {1'h0, 8'ha0 + v[7:0]});
      wr(v, 9'h100);
      tx_wr_i = '0;
      rd(v, c, p);
      chk(c, a);
      chk(arr_q, {v[1:0], v[0], a});
      rd(v, c, p);
      chk(c, 8'ha0 + v[7:0]);
      rd(v, c, p);
      chk({c[8], p}, 2'h3);
      rx_rd_i = '0;
      step();
      chk({rx_valid_o, rx_pkt_pending_o}, 8'h0);
    end
  endtask : t_pkt
  task automatic t_fill();
    logic [8:0] c;
    logic p;
    int n;
    stall = 1;
    n = 0;
    while (tx_ready_o[2] && n < 40)
    begin
      tx_wr_i = 4'h4;
      tx_char_i = n[8:0];
      n++;
      step();
    end
    tx_char_i = 9'h0ee;
    step();
    tx_wr_i = '0;
    chk(n >= 33, 1);
    stall = 0;
    wr(2, 9'h100);
    tx_wr_i = '0;
    for (int i = 0; i < n; i++)
    begin
      rd(2, c, p);
      chk(c, i);
    end
    rd(2, c, p);
    chk(c[8], 1);
    rx_rd_i = '0;
  endtask : t_fill
  task automatic t_bc();
    bc_sub_mask_i = 16'h0004;
    stall = 1;
    b1 = {8'h07, 8'h01, 8'h12, 1'h0, 64'h0123456789abcdef};
    bc_tx_i = b1;
    bc_tx_wr_i = 1;
    step();
    bc_tx_i = ~b1;
    step();
    bc_tx_wr_i = 0;
    chk(link_bc_tx_o, b1);
    stall = 0;
    repeat (3) step();
    chk({nt_n[1:0], bc_rx_o}, {2'h1, b1});
    bc_tx_i = b1;
    bc_tx_i.btype = 8'h13;
    bc_tx_wr_i = 1;
    step();
    bc_tx_wr_i = 0;
    repeat (4) step();
    chk({nt_n[1:0], bc_rx_o}, {2'h1, b1});
  endtask : t_bc
  initial
  begin
    sys_rst_i = 1;
    stall = 0;
    tx_wr_i = '0;
    tx_char_i = '0;
    rx_rd_i = '0;
    bc_tx_wr_i = 0;
    bc_tx_i = '0;
    bc_sub_mask_i = '0;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    nt_n = 0;
    repeat (4) @(posedge core_clk_i);
    #1 sys_rst_i = 0;
    chk({tx_ready_o, link_rx_ready_o}, 8'hff);
    t_pkt();
    t_fill();
    t_bc();
    summarize();
  end
endmodule : vcps_port_bench
